// [pkg/hvms_regs.svh]
// Bit positions, reset values and widths of the high-voltage monitor status register
`ifndef HVMS_REGS_SVH
`define HVMS_REGS_SVH

`define HVMS_WIDTH          8
`define HVMS_RESET          8'h00
`define HVMS_BIT_WAKE_PIN   7
`define HVMS_BIT_THERMAL    6
`define HVMS_BIT_TIF_PIN    5
`define HVMS_BIT_ADC_BUF    4
`define HVMS_BIT_LVF_OK     3
`define HVMS_BIT_BUS_SC     2
`define HVMS_BIT_TIF_SC     1
`define HVMS_BIT_WAKE_SC    0

`endif

// [pkg/hvms_pkg.sv]
// Types shared by the high-voltage monitor status block
`default_nettype none

package hvms_pkg;

   // Read-answer sequencer, one-hot
   typedef enum logic [1:0] {
      HVMS_IDLE   = 2'h1,
      HVMS_ANSWER = 2'h2
   } hvms_state_e;

   // One status byte
   typedef logic [7:0] hvms_byte_t;

endpackage

`default_nettype wire

// [verilog/hvms_flag.sv]
// Sticky status flag: hardware sets, a clear strobe resets, set wins
`timescale 1ns/100ps
`default_nettype none

module hvms_flag (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);

   logic flag_ff;     // Held flag
   logic nxt_flag;    // Next value

   // A set arriving with the clear is kept, so no event is lost
   always_comb begin
      if (set_i) begin
         nxt_flag = 1'b1;
      end else if (clr_i) begin
         nxt_flag = 1'b0;
      end else begin
         nxt_flag = flag_ff;
      end
   end

   // Flag register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag_o = flag_ff;

endmodule

`default_nettype wire

// [verilog/hvms_top.sv]
// High-voltage monitor status register with its indirect read port
//
// Function
// (RULE1) Bit 7 shows wake pin when input enabled
// (RULE2) Bit 5 shows test pin when input enabled
// (RULE3) Bit 6 flags thermal shutdown occurred
// (RULE4) Bit 4 shows ADC input buffer enable
// (RULE5) Bit 3 zero if supply fell low
// (RULE6) Low-voltage flag cleared only by re-enable
// (RULE7) Bit 2 bus driver short, re-enable clears
// (RULE8) Bit 1 test driver short, re-enable clears
// (RULE9) Bit 0 flags wake driver short
// (RULE10) Read only through command/data interface
// (RULE11) Driver re-enable bit clears itself
// (RULE12) Pin input enable drives read-back bits
`timescale 1ns/100ps
`default_nettype none
`include "hvms_regs.svh"

module hvms_top (
   input wire logic CLK_I,
   input wire logic SRST_I,
   // Indirect read request from the command interface
   input wire logic MON_RD_I,
   // Configuration controls
   input wire logic PIN_IN_EN_I,
   input wire logic DRV_REEN_WR_I,
   input wire logic LVF_EN_I,
   input wire logic LVF_REEN_WR_I,
   // Live conditions
   input wire logic WAKE_PIN_I,
   input wire logic TEST_IF_PIN_I,
   input wire logic THERM_SHDN_I,
   input wire logic ADC_BUF_EN_I,
   input wire logic SUPPLY_LOW_I,
   input wire logic BUS_SC_I,
   input wire logic TIF_SC_I,
   input wire logic WAKE_SC_I,
   // Outputs
   output logic DRV_REEN_O,
   output logic [`HVMS_WIDTH-1:0] MON_LIVE_O,
   output logic [`HVMS_WIDTH-1:0] MON_DATA_O,
   output logic MON_VALID_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   hvms_pkg::hvms_state_e state_ff;      // Read sequencer state
   hvms_pkg::hvms_state_e nxt_state;     // Its next value
   logic drv_reen_ff;                    // Self-clearing driver re-enable
   logic [`HVMS_WIDTH-1:0] live_ff;      // Registered live status
   logic [`HVMS_WIDTH-1:0] data_ff;      // Captured read answer
   logic valid_ff;                       // Answer strobe
   hvms_pkg::hvms_byte_t mon_status;     // Assembled status byte
   logic therm_flag;                     // Thermal event seen
   logic supply_low_flag;                // Supply dipped since last re-enable
   logic bus_sc_flag;                    // Bus driver short seen
   logic tif_sc_flag;                    // Test driver short seen
   logic wake_sc_flag;                   // Wake driver short seen

   ////////////////////////////////////////////////////////////////////////////
   // Driver re-enable strobe

   // Written 1 lasts exactly one cycle; a second write in that cycle is merged
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         drv_reen_ff <= 1'b0;
      end else begin
         drv_reen_ff <= DRV_REEN_WR_I & ~drv_reen_ff; // see (RULE11)
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event flags

   // Thermal flag; the re-enable that restores the pins also clears it
   hvms_flag u_therm (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .set_i(THERM_SHDN_I),         // see (RULE3)
      .clr_i(drv_reen_ff),
      .flag_o(therm_flag)
   );

   // Supply dip memory; only a low-voltage re-enable write clears it
   hvms_flag u_lvf (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .set_i(SUPPLY_LOW_I),         // see (RULE5)
      .clr_i(LVF_REEN_WR_I),        // see (RULE6)
      .flag_o(supply_low_flag)
   );

   // Bus driver short
   hvms_flag u_bus_sc (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .set_i(BUS_SC_I),
      .clr_i(drv_reen_ff),          // see (RULE7)
      .flag_o(bus_sc_flag)
   );

   // Test-interface driver short
   hvms_flag u_tif_sc (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .set_i(TIF_SC_I),
      .clr_i(drv_reen_ff),          // see (RULE8)
      .flag_o(tif_sc_flag)
   );

   // Wake driver short; held until the pins are re-enabled
   hvms_flag u_wake_sc (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .set_i(WAKE_SC_I),            // see (RULE9)
      .clr_i(drv_reen_ff),
      .flag_o(wake_sc_flag)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status byte assembly

   // Pin read-back is gated so a disabled input reads as 0, not a floating level
   always_comb begin
      mon_status = `HVMS_RESET;
      mon_status[`HVMS_BIT_WAKE_PIN] = PIN_IN_EN_I & WAKE_PIN_I;    // see (RULE1) (RULE12)
      mon_status[`HVMS_BIT_THERMAL] = therm_flag;                   // see (RULE3)
      mon_status[`HVMS_BIT_TIF_PIN] = PIN_IN_EN_I & TEST_IF_PIN_I;  // see (RULE2) (RULE12)
      mon_status[`HVMS_BIT_ADC_BUF] = ADC_BUF_EN_I;                 // see (RULE4)
      mon_status[`HVMS_BIT_LVF_OK] = LVF_EN_I & ~supply_low_flag;   // see (RULE5)
      mon_status[`HVMS_BIT_BUS_SC] = bus_sc_flag;                   // see (RULE7)
      mon_status[`HVMS_BIT_TIF_SC] = tif_sc_flag;                   // see (RULE8)
      mon_status[`HVMS_BIT_WAKE_SC] = wake_sc_flag;                 // see (RULE9)
   end

   // Live copy for the high-voltage logic, one cycle behind
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         live_ff <= `HVMS_RESET;
      end else begin
         live_ff <= mon_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Indirect read sequencer

   // A request taken in IDLE is answered next cycle; requests while answering are dropped
   always_comb begin
      case (state_ff)
         hvms_pkg::HVMS_IDLE: begin
            nxt_state = MON_RD_I ? hvms_pkg::HVMS_ANSWER : hvms_pkg::HVMS_IDLE;
         end
         hvms_pkg::HVMS_ANSWER: begin
            nxt_state = hvms_pkg::HVMS_IDLE;
         end
         default: begin
            nxt_state = hvms_pkg::HVMS_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         state_ff <= hvms_pkg::HVMS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Answer capture; data holds until the next request is taken
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         data_ff <= `HVMS_RESET;
         valid_ff <= 1'b0;
      end else begin
         valid_ff <= (state_ff == hvms_pkg::HVMS_IDLE) & MON_RD_I;   // see (RULE10)
         if ((state_ff == hvms_pkg::HVMS_IDLE) && MON_RD_I) begin
            data_ff <= mon_status;                                  // see (RULE10)
         end
      end
   end

   assign DRV_REEN_O = drv_reen_ff;
   assign MON_LIVE_O = live_ff;
   assign MON_DATA_O = data_ff;
   assign MON_VALID_O = valid_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);

   wake_readback_a: assert property ( // see (RULE1)
      !$past(SRST_I) |->
      MON_LIVE_O[`HVMS_BIT_WAKE_PIN] == $past(PIN_IN_EN_I && WAKE_PIN_I))
      else $error("wake pin read-back wrong");

   // Checks both the gated-off case and the live-follow case
   tif_readback_a: assert property ( // see (RULE2)
      !$past(SRST_I) |->
      MON_LIVE_O[`HVMS_BIT_TIF_PIN] == $past(PIN_IN_EN_I && TEST_IF_PIN_I))
      else $error("test pin read-back wrong");

   thermal_seen_a: assert property ( // see (RULE3)
      THERM_SHDN_I |-> ##2 MON_LIVE_O[`HVMS_BIT_THERMAL])
      else $error("thermal event not shown");

   adc_buf_a: assert property ( // see (RULE4)
      !$past(SRST_I) |-> MON_LIVE_O[`HVMS_BIT_ADC_BUF] == $past(ADC_BUF_EN_I))
      else $error("buffer enable bit wrong");

   supply_low_a: assert property ( // see (RULE5)
      SUPPLY_LOW_I |-> ##2 !MON_LIVE_O[`HVMS_BIT_LVF_OK])
      else $error("supply dip not shown");

   lvf_hold_a: assert property ( // see (RULE6)
      supply_low_flag && !LVF_REEN_WR_I |=> supply_low_flag)
      else $error("low-voltage memory lost");

   bus_sc_clear_a: assert property ( // see (RULE7)
      DRV_REEN_WR_I && !drv_reen_ff ##1 !BUS_SC_I |=> !bus_sc_flag)
      else $error("bus short not cleared");

   tif_sc_seen_a: assert property ( // see (RULE8)
      TIF_SC_I |=> tif_sc_flag ##1 MON_LIVE_O[`HVMS_BIT_TIF_SC])
      else $error("test driver short not shown");

   wake_sc_seen_a: assert property ( // see (RULE9)
      WAKE_SC_I |-> ##2 MON_LIVE_O[`HVMS_BIT_WAKE_SC])
      else $error("wake short not shown");

   reen_pulse_a: assert property ( // see (RULE11)
      DRV_REEN_O |=> !DRV_REEN_O)
      else $error("re-enable did not clear");

   read_answer_a: assert property ( // see (RULE10)
      state_ff == hvms_pkg::HVMS_IDLE && MON_RD_I |=>
      MON_VALID_O && MON_DATA_O == $past(mon_status) ##1 !MON_VALID_O)
      else $error("read answer wrong");

endmodule

`default_nettype wire

// [verification/tb_top.sv]
// Self-checking testbench for the high-voltage monitor status block
`timescale 1ns/100ps
`default_nettype none
`include "hvms_regs.svh"

// Compares one design value with its expectation and counts the result
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin n_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp); end end

module tb_top;
   ////////////////////////////////////////////////////////////////////////////////
   logic clk = 1'b0; // 250 MHz clock
   logic srst = 1'b1; // Held high at start
   logic rd = 1'b0, pin_en = 1'b0, drv_wr = 1'b0, lvf_en = 1'b0, lvf_wr = 1'b0;
   logic wake = 1'b0, tif = 1'b0, therm = 1'b0, adc = 1'b0, low = 1'b0;
   logic bus_sc = 1'b0, tif_sc = 1'b0, wake_sc = 1'b0;
   logic drv_reen; // Self-clearing re-enable pulse
   hvms_pkg::hvms_byte_t live, data; // Live byte and answer byte
   logic valid; // Answer strobe
   int n_errors = 0;
   int n_checks = 0;

   hvms_top i_hvms_top (.CLK_I(clk), .SRST_I(srst), .MON_RD_I(rd), .PIN_IN_EN_I(pin_en),
      .DRV_REEN_WR_I(drv_wr), .LVF_EN_I(lvf_en), .LVF_REEN_WR_I(lvf_wr), .WAKE_PIN_I(wake),
      .TEST_IF_PIN_I(tif), .THERM_SHDN_I(therm), .ADC_BUF_EN_I(adc), .SUPPLY_LOW_I(low),
      .BUS_SC_I(bus_sc), .TIF_SC_I(tif_sc), .WAKE_SC_I(wake_sc), .DRV_REEN_O(drv_reen),
      .MON_LIVE_O(live), .MON_DATA_O(data), .MON_VALID_O(valid));

   // Free-running clock, 4 ns period
   initial begin
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Inputs move on falling edges so every rising edge sees settled values
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Outputs stay cleared while reset is held
   task automatic t_reset;
      `CHK(live, `HVMS_RESET)
      `CHK({valid, drv_reen}, 2'h0)
   endtask

   // Pin read-back follows the pins only with input mode on
   task automatic t_pins;
      wake = 1'b1;
      tif = 1'b1;
      step(2);
      `CHK(live, 8'h00)
      pin_en = 1'b1;
      step(2);
      `CHK(live, 8'hA0)
      wake = 1'b0;
      step(2);
      `CHK(live, 8'h20)
      wake = 1'b1;
      tif = 1'b0;
      step(2);
      `CHK(live, 8'h80)
      adc = 1'b1;
      step(2);
      `CHK(live, 8'h90)
      pin_en = 1'b0;
      adc = 1'b0;
      step(2);
      `CHK(live[`HVMS_BIT_ADC_BUF], 1'b0)
   endtask

   // The thermal and three driver-short flags each set alone, then one re-enable write clears it
   task automatic t_flags;
      int pos[4] = '{`HVMS_BIT_THERMAL, `HVMS_BIT_BUS_SC, `HVMS_BIT_TIF_SC, `HVMS_BIT_WAKE_SC};
      for (int i = 0; i < 4; i++) begin
         {therm, bus_sc, tif_sc, wake_sc} = 4'h8 >> i;
         step(1);
         {therm, bus_sc, tif_sc, wake_sc} = 4'h0;
         step(4);
         `CHK(live, 8'h01 << pos[i])
         drv_wr = 1'b1;
         step(1);
         drv_wr = 1'b0;
         `CHK(drv_reen, 1'b1)
         step(1);
         `CHK(drv_reen, 1'b0)
         step(1);
         `CHK(live, 8'h00)
      end
   endtask

   // A short arriving with the clear strobe survives it; a two-cycle write gives one pulse
   task automatic t_merge;
      drv_wr = 1'b1;
      step(1);
      `CHK(drv_reen, 1'b1)
      bus_sc = 1'b1;
      step(1);
      drv_wr = 1'b0;
      bus_sc = 1'b0;
      `CHK(drv_reen, 1'b0)
      step(1);
      `CHK(live[`HVMS_BIT_BUS_SC], 1'b1)
      drv_wr = 1'b1;
      step(1);
      drv_wr = 1'b0;
      step(2);
      `CHK(live, 8'h00)
   endtask

   // Supply dip memory survives until the flag function is re-enabled
   task automatic t_lvf;
      lvf_en = 1'b1;
      step(2);
      `CHK(live[`HVMS_BIT_LVF_OK], 1'b1)
      low = 1'b1;
      step(1);
      low = 1'b0;
      step(2);
      `CHK(live[`HVMS_BIT_LVF_OK], 1'b0)
      drv_wr = 1'b1;
      step(1);
      drv_wr = 1'b0;
      step(4);
      `CHK(live[`HVMS_BIT_LVF_OK], 1'b0)
      lvf_wr = 1'b1;
      step(1);
      lvf_wr = 1'b0;
      step(1);
      `CHK(live[`HVMS_BIT_LVF_OK], 1'b1)
      lvf_en = 1'b0;
      step(2);
   endtask

   // Indirect read: answer one cycle later, back-to-back request ignored
   task automatic t_read;
      adc = 1'b1;
      wake = 1'b1;
      pin_en = 1'b1;
      step(3);
      rd = 1'b1;
      step(1);
      `CHK({valid, data}, 9'h190)
      step(1);
      rd = 1'b0;
      `CHK(valid, 1'b0)
      adc = 1'b0;
      step(3);
      `CHK(data, 8'h90)
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      `CHK({valid, data}, 9'h180)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run
   task automatic results;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      step(20);
      t_reset();
      srst = 1'b0;
      step(1);
      t_pins();
      t_flags();
      t_merge();
      t_lvf();
      t_read();
      results();
   end

   // Watchdog: the whole sequence needs well under 1 us
   initial begin
      #20000;
      n_errors++;
      results();
   end
endmodule
`default_nettype wire
